// file: src/gia_top.sv
// Top of the grouped interrupt aggregator register block
//
// Function
// - A pending bit latches on its event, ignores the enable, clears only by a one-write.
// - Bits with no event source, and bit 31, read back as zero.
// - Bits of absent pin sources are reserved in all four group registers.
// - Each bit has its own enable and only enabled bits raise the group.
// - A one written to enable-set turns that enable on; a zero leaves it.
// - A one written to enable-clear turns that enable off; a zero leaves it.
// - Enable-set and enable-clear share one enable flop per bit.
// - Reading enable-set or enable-clear returns the live enables.
// - A masked-status bit is one exactly when pending and enable are both one.
// - The masked-status register is read-only and writes to it do nothing.
// - Route-enable-set at 0x200 bits 26:8 lets a group raise its interrupt.
// - A zero written to route-enable-set leaves that group's routing as is.
// - A one written at 0x204 bits 26:8 stops that group's interrupt.
// - A group with routing off shows zero in the vector and raises nothing.
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
module gia_top (
   // Clock and reset
   input  wire logic   i_sys_clk,
   input  wire logic   i_rst,
   // APB slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic             o_pready,
   output logic [31:0]      o_prdata,
   output logic             o_pslverr,
   // Event sources, asynchronous, one row per group
   input  wire logic [18:0][30:0] i_event,
   // Group requests to the processor interrupt controller
   output logic [18:0]      o_grp_irq
);

   gia_bus_if bus ();

   logic [18:0][30:0] ev_meta;
   logic [18:0][30:0] ev_sync;
   logic [18:0][30:0] pend;
   logic [18:0][30:0] en;
   logic [18:0][30:0] msk;
   logic [18:0]       any_g;
   logic [18:0]       route;
   logic [18:0]       active;
   logic [18:0]       wr_src;
   logic [18:0]       wr_eset;
   logic [18:0]       wr_eclr;
   logic [18:0]       wbits;
   gia_pkg::gia_dec_s dec;

   // One clock domain: every check samples on the system clock, off in reset
   default clocking cb @(posedge i_sys_clk);
   endclocking

   default disable iff (i_rst);

   // Bus front end
   gia_apb_slave u_apb (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_psel    (i_psel),
      .i_penable (i_penable),
      .i_pwrite  (i_pwrite),
      .i_paddr   (i_paddr),
      .i_pwdata  (i_pwdata),
      .o_pready  (o_pready),
      .o_prdata  (o_prdata),
      .o_pslverr (o_pslverr),
      .bus       (bus)
   );

   // One decode serves both the write strobes and the read mux
   assign dec     = gia_pkg::gia_decode(bus.addr);
   assign bus.hit = (dec.kind != gia_pkg::K_NONE);
   assign wbits   = bus.wdata[gia_pkg::ROUTE_MSB:gia_pkg::ROUTE_LSB];

   // Events come from other clock domains: two flops before use
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         ev_meta <= '0;
         ev_sync <= '0;
      end else begin
         ev_meta <= i_event;
         ev_sync <= ev_meta;
      end
   end

   // Per-group write strobes and group state
   for (genvar g = 0; g < gia_pkg::NGRP; g++) begin : g_grp
      logic sel;
      assign sel = bus.wr && (dec.grp == 5'(g));
      // Writes to the masked-status word decode to no strobe at all
      assign wr_src[g]  = sel && (dec.kind == gia_pkg::K_SRC);
      assign wr_eset[g] = sel && (dec.kind == gia_pkg::K_ESET);
      assign wr_eclr[g] = sel && (dec.kind == gia_pkg::K_ECLR);

      gia_group #(
         .IMPL (gia_pkg::IMPL_MASK[g])
      ) u_grp (
         .i_sys_clk (i_sys_clk),
         .i_rst     (i_rst),
         .i_event   (ev_sync[g]),
         .i_wr_src  (wr_src[g]),
         .i_wr_eset (wr_eset[g]),
         .i_wr_eclr (wr_eclr[g]),
         .i_wdata   (bus.wdata[30:0]),
         .o_pending (pend[g]),
         .o_enable  (en[g]),
         .o_masked  (msk[g]),
         .o_any     (any_g[g])
      );

      // Checks per group
      chk_pend_hold: assert property (
         !wr_src[g] |=> ((pend[g] & $past(pend[g])) == $past(pend[g]))
      ) else $error("pending bit dropped without a clear");

      chk_pend_w1c: assert property (
         (wr_src[g] && ev_sync[g] == '0)
         |=> pend[g] == ($past(pend[g]) & ~$past(bus.wdata[30:0]))
      ) else $error("one-write did not clear exactly the written bits");

      chk_pend_set: assert property (
         wr_src[g] |=> ((pend[g] & $past(ev_sync[g]))
                        == ($past(ev_sync[g]) & gia_pkg::IMPL_MASK[g]))
      ) else $error("event lost against a clear in the same cycle");

      chk_en_set: assert property (
         wr_eset[g] |=> ((en[g] & $past(en[g])) == $past(en[g])
                         && (en[g] & $past(bus.wdata[30:0]))
                            == ($past(bus.wdata[30:0]) & gia_pkg::IMPL_MASK[g]))
      ) else $error("enable-set write wrong");

      chk_en_clr: assert property (
         wr_eclr[g] |=> (en[g] == ($past(en[g]) & ~$past(bus.wdata[30:0])))
      ) else $error("enable-clear write wrong");

      chk_en_shared: assert property (
         !(wr_eset[g] || wr_eclr[g]) |=> en[g] == $past(en[g])
      ) else $error("enable moved without a write");

      chk_rsvd_zero: assert property (
         ((pend[g] | en[g]) & ~gia_pkg::IMPL_MASK[g]) == '0
      ) else $error("reserved bit became set");

      // A synchronised event always lands, whatever the bus does meanwhile
      chk_pend_latch: assert property (
         ##1 ((pend[g] & $past(ev_sync[g]))
              == ($past(ev_sync[g]) & gia_pkg::IMPL_MASK[g]))
      ) else $error("synchronised event did not set its pending bit");
   end

   // Routing enables: one-writes set at 0x200 and clear at 0x204
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         route <= gia_pkg::RST_ROUTE;
      end else if (bus.wr && dec.kind == gia_pkg::K_BSET) begin
         route <= route | wbits;
      end else if (bus.wr && dec.kind == gia_pkg::K_BCLR) begin
         route <= route & ~wbits;
      end
   end

   // A disabled group can show pending bits yet never asserts
   assign active = any_g & route;

   // Registered so the processor sees a glitch-free level
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_grp_irq <= gia_pkg::RST_ROUTE;
      end else begin
         o_grp_irq <= active;
      end
   end

   // Read mux; bit 31 and unassigned bits always read zero
   always_comb begin
      bus.rdata = gia_pkg::RST_RDATA;
      unique case (dec.kind)
         gia_pkg::K_SRC: begin
            bus.rdata = {1'b0, pend[dec.grp]};
         end
         gia_pkg::K_ESET, gia_pkg::K_ECLR: begin
            bus.rdata = {1'b0, en[dec.grp]};
         end
         gia_pkg::K_RES: begin
            bus.rdata = {1'b0, msk[dec.grp]};
         end
         gia_pkg::K_BSET, gia_pkg::K_BCLR: begin
            bus.rdata[gia_pkg::ROUTE_MSB:gia_pkg::ROUTE_LSB] = route;
         end
         gia_pkg::K_BVEC: begin
            bus.rdata[gia_pkg::ROUTE_MSB:gia_pkg::ROUTE_LSB] = active;
         end
         gia_pkg::K_NONE: begin
            bus.rdata = gia_pkg::RST_RDATA;
         end
      endcase
   end

   // Checks on the whole block
   sequence rd_setup(gia_pkg::gia_kind_e k);
      i_psel && !i_penable && !i_pwrite && dec.kind == k;
   endsequence

   chk_result_read: assert property (
      rd_setup(gia_pkg::K_RES)
      |=> o_prdata == {1'b0, $past(pend[dec.grp] & en[dec.grp])}
   ) else $error("masked status read differs from pending and enable");

   chk_bit31_zero: assert property (
      (rd_setup(gia_pkg::K_SRC) or rd_setup(gia_pkg::K_ESET)
       or rd_setup(gia_pkg::K_ECLR)) |=> !o_prdata[31]
   ) else $error("bit 31 of a group register read as one");

   chk_en_readback: assert property (
      (rd_setup(gia_pkg::K_ESET) or rd_setup(gia_pkg::K_ECLR))
      |=> o_prdata[30:0] == $past(en[dec.grp])
   ) else $error("enable read does not show live enables");

   chk_result_ro: assert property (
      (bus.wr && dec.kind == gia_pkg::K_RES)
      |=> en == $past(en) && route == $past(route)
   ) else $error("write to masked status changed state");

   chk_route_set: assert property (
      (bus.wr && dec.kind == gia_pkg::K_BSET)
      |=> route == ($past(route) | $past(wbits))
   ) else $error("route set write wrong");

   chk_route_clr: assert property (
      (bus.wr && dec.kind == gia_pkg::K_BCLR)
      |=> (route & $past(wbits)) == '0 ##1 (o_grp_irq & $past(wbits, 2)) == '0
   ) else $error("route clear did not stop the group");

   chk_irq_gated: assert property (
      ##1 o_grp_irq == ($past(route) & $past(any_g))
   ) else $error("group interrupt not masked-status OR gated by routing");

   chk_vec_zero: assert property (
      rd_setup(gia_pkg::K_BVEC)
      |=> (o_prdata[gia_pkg::ROUTE_MSB:gia_pkg::ROUTE_LSB] & ~$past(route)) == '0
   ) else $error("vector shows a group with routing off");

   chk_reset_clear: assert property (
      $past(i_rst) |-> route == '0 && en == '0 && pend == '0 && o_grp_irq == '0
   ) else $error("state not zero after reset");

   chk_unmapped_err: assert property (
      (i_psel && !i_penable && dec.kind == gia_pkg::K_NONE) |=> o_pslverr
   ) else $error("unmapped access without error");

   // Mapped words never answer with an error
   chk_mapped_ok: assert property (
      (i_psel && !i_penable && dec.kind != gia_pkg::K_NONE) |=> !o_pslverr
   ) else $error("mapped access answered with an error");

   chk_unmapped_zero: assert property (
      (i_psel && !i_penable && dec.kind == gia_pkg::K_NONE) |=> o_prdata == '0
   ) else $error("unmapped read returned nonzero data");

   // The slave never stalls, so a master never waits
   chk_pready_high: assert property (
      o_pready
   ) else $error("ready dropped");

   // Read data only moves in a setup cycle; the master may sample it late
   chk_rdata_stable: assert property (
      !(i_psel && !i_penable) |=> $stable(o_prdata)
   ) else $error("read data moved outside a setup cycle");

   chk_src_read: assert property (
      rd_setup(gia_pkg::K_SRC) |=> o_prdata[30:0] == $past(pend[dec.grp])
   ) else $error("pending read differs from pending flags");

   chk_route_read: assert property (
      (rd_setup(gia_pkg::K_BSET) or rd_setup(gia_pkg::K_BCLR))
      |=> o_prdata[26:8] == $past(route)
   ) else $error("route read differs from routing enables");

   // Reserved parts of the route words read zero
   chk_route_rsvd: assert property (
      (rd_setup(gia_pkg::K_BSET) or rd_setup(gia_pkg::K_BCLR) or rd_setup(gia_pkg::K_BVEC))
      |=> o_prdata[31:27] == '0 && o_prdata[7:0] == '0
   ) else $error("reserved route bits read as one");

   chk_vec_exact: assert property (
      rd_setup(gia_pkg::K_BVEC) |=> o_prdata[26:8] == $past(any_g & route)
   ) else $error("vector read differs from gated group requests");

   // A write cycle carries no stale read data back
   chk_wr_rdzero: assert property (
      (i_psel && !i_penable && i_pwrite) |=> o_prdata == '0
   ) else $error("write cycle returned read data");

   // Main scenarios
   cov_irq_rise: cover property ($rose(o_grp_irq[0]));
   cov_clear_race: cover property (wr_src[0] && ev_sync[0] != '0);
   cov_route_off: cover property ((bus.wr && dec.kind == gia_pkg::K_BCLR) && any_g != '0);
   cov_vec_read: cover property (rd_setup(gia_pkg::K_BVEC) ##1 o_prdata != '0);
   cov_en_clear: cover property (wr_eclr != '0 && en != '0);

endmodule : gia_top

// file: src/gia_pkg.sv
// Package: register map, reset values and address decode of the aggregator
package gia_pkg;
   localparam int NGRP      = 19;       // Groups 8 to 26
   localparam int EVW       = 31;       // Event bits per group
   localparam int ROUTE_LSB = 8;
   localparam int ROUTE_MSB = 26;
   localparam int SYNC_LEN  = 2;

   localparam logic [11:0] GRP_STRIDE = 12'h014;
   localparam logic [11:0] OFS_SRC    = 12'h000;
   localparam logic [11:0] OFS_ESET   = 12'h004;
   localparam logic [11:0] OFS_RES    = 12'h008;
   localparam logic [11:0] OFS_ECLR   = 12'h00c;
   localparam logic [11:0] OFS_BSET   = 12'h200;
   localparam logic [11:0] OFS_BCLR   = 12'h204;
   localparam logic [11:0] OFS_BVEC   = 12'h208;

   localparam logic [30:0] RST_FLAGS = 31'h00000000;
   localparam logic [18:0] RST_ROUTE = 19'h00000;
   localparam logic [31:0] RST_RDATA = 32'h00000000;

   typedef logic [30:0] gia_bits_t;

   // Implemented event bits per group; cleared bits are reserved, read zero
   localparam gia_bits_t IMPL_MASK [NGRP] = '{default: 31'h7fffffff};

   typedef enum logic [2:0] {
      K_SRC  = 3'b000,
      K_ESET = 3'b001,
      K_RES  = 3'b010,
      K_ECLR = 3'b011,
      K_BSET = 3'b100,
      K_BCLR = 3'b101,
      K_BVEC = 3'b110,
      K_NONE = 3'b111
   } gia_kind_e;

   typedef struct packed {
      gia_kind_e  kind;
      logic [4:0] grp;
   } gia_dec_s;

   // Maps a byte address to a register kind and group index
   function automatic gia_dec_s gia_decode(input logic [11:0] addr);
      gia_dec_s    d;
      logic [11:0] base;
      d.kind = K_NONE;
      d.grp  = 5'h00;
      base   = 12'h000;
      if (addr == OFS_BSET) d.kind = K_BSET;
      if (addr == OFS_BCLR) d.kind = K_BCLR;
      if (addr == OFS_BVEC) d.kind = K_BVEC;
      for (int g = 0; g < NGRP; g++) begin
         base = GRP_STRIDE * 12'(g);
         if (addr == base + OFS_SRC) begin
            d.kind = K_SRC;
            d.grp  = 5'(g);
         end
         if (addr == base + OFS_ESET) begin
            d.kind = K_ESET;
            d.grp  = 5'(g);
         end
         if (addr == base + OFS_RES) begin
            d.kind = K_RES;
            d.grp  = 5'(g);
         end
         if (addr == base + OFS_ECLR) begin
            d.kind = K_ECLR;
            d.grp  = 5'(g);
         end
      end
      return d;
   endfunction : gia_decode
endpackage : gia_pkg

// file: src/gia_bus_if.sv
// Interface: register access between the APB slave and the register file
`timescale 1ns/10ps
interface gia_bus_if;
   logic        wr;     // Write takes effect this edge
   logic [11:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;  // Read value of addr
   logic        hit;    // addr names a register

   modport slave (output wr, addr, wdata, input rdata, hit);
   modport regs  (input wr, addr, wdata, output rdata, hit);
endinterface : gia_bus_if

// file: src/gia_apb_slave.sv
// Zero-wait APB slave front end of the aggregator
`timescale 1ns/10ps
module gia_apb_slave (
   // Clock and reset
   input  wire logic   i_sys_clk,
   input  wire logic   i_rst,
   // APB
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic             o_pready,
   output logic [31:0]      o_prdata,
   output logic             o_pslverr,
   // Register side
   gia_bus_if.slave bus
);
   // Never stalls: every access completes in its first access cycle
   assign o_pready  = 1'b1;
   assign bus.addr  = i_paddr;
   assign bus.wdata = i_pwdata;
   assign bus.wr    = i_psel & i_penable & i_pwrite;

   // Read data and error are caught in setup so they come from flops
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_prdata  <= gia_pkg::RST_RDATA;
         o_pslverr <= 1'b0;
      end else if (i_psel && !i_penable) begin
         o_prdata  <= i_pwrite ? gia_pkg::RST_RDATA : bus.rdata;
         o_pslverr <= !bus.hit;
      end
   end
endmodule : gia_apb_slave

// file: src/gia_group.sv
// One event group: sticky pending flags, shared enables, masked status
`timescale 1ns/10ps
module gia_group #(
   parameter gia_pkg::gia_bits_t IMPL = 31'h7fffffff
) (
   // Clock and reset
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst,
   // Synchronised events and register writes
   input  wire logic [30:0] i_event,
   input  wire logic        i_wr_src,
   input  wire logic        i_wr_eset,
   input  wire logic        i_wr_eclr,
   input  wire logic [30:0] i_wdata,
   // State
   output logic [30:0]      o_pending,
   output logic [30:0]      o_enable,
   output logic [30:0]      o_masked,
   output logic             o_any
);
   // Pending: event set wins over a one-write clear in the same cycle
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pending <= gia_pkg::RST_FLAGS;
      end else begin
         o_pending <= ((o_pending & ~({31{i_wr_src}} & i_wdata)) | i_event) & IMPL;
      end
   end

   // One enable flop per bit, set and cleared from two addresses
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_enable <= gia_pkg::RST_FLAGS;
      end else if (i_wr_eset) begin
         o_enable <= (o_enable | i_wdata) & IMPL;
      end else if (i_wr_eclr) begin
         o_enable <= o_enable & ~i_wdata;
      end
   end

   // Only enabled bits reach the group request
   assign o_masked = o_pending & o_enable;
   assign o_any    = |o_masked;
endmodule : gia_group

// file: tb/gia_evt_src.sv
// Partner model: peripheral event sources feeding the aggregator
`timescale 1ns/10ps
module gia_evt_src (
   // Clock and reset
   input  wire logic              i_sys_clk,
   input  wire logic              i_rst,
   // Requests from the bench
   input  wire logic              i_fire,
   input  wire logic [4:0]        i_grp,
   input  wire logic [30:0]       i_bits,
   // Event lines towards the aggregator
   output logic [18:0][30:0]      o_event
);
   logic [1:0] hold;

   // Event held two cycles so the two-flop sync sees it; idle sources sit low
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_event <= '0;
         hold    <= 2'h0;
      end else if (i_fire) begin
         o_event        <= '0;
         o_event[i_grp] <= i_bits;
         hold           <= 2'h2;
      end else if (hold == 2'h1) begin
         o_event <= '0;
         hold    <= 2'h0;
      end else if (hold != 2'h0) begin
         hold <= hold - 2'h1;
      end
   end
endmodule : gia_evt_src

// file: tb/tb.sv
// Testbench: random register traffic and events against a reference model
`timescale 1ns/10ps
module tb;
   logic                 i_sys_clk, i_rst, psel, penable, pwrite, pready, pslverr, fire;
   logic [11:0]          paddr;
   logic [31:0]          pwdata, prdata, v, d;
   logic [4:0]           fgrp;
   logic [30:0]          fbits;
   logic [18:0][30:0]    events;
   logic [18:0]          irq, route;
   gia_pkg::gia_bits_t   pend [19];
   gia_pkg::gia_bits_t   en [19];
   int                   n_fail, checks_done, cyc, g, op;
   integer               seed;

   gia_top gia_top_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .i_event(events),
      .o_grp_irq(irq));
   gia_evt_src gia_evt_src_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_fire(fire),
      .i_grp(fgrp), .i_bits(fbits), .o_event(events));

   // Free-running clock, 25 ns period
   initial begin
      i_sys_clk = 1'b0;
      forever #12.5 i_sys_clk = ~i_sys_clk;
   end

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish

   // Hang guard, far above the few thousand cycles the run needs
   always @(posedge i_sys_clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // One APB transfer; holds the request until pready is seen high, giving up after 20 access cycles
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge i_sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge i_sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge i_sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   function automatic logic [11:0] gaddr(input int gi, input logic [11:0] ofs);
      return gia_pkg::GRP_STRIDE * 12'(gi) + ofs;
   endfunction : gaddr

   // Expected group requests: OR of masked status, gated by routing
   function automatic logic [18:0] exp_irq();
      logic [18:0] r;
      for (int k = 0; k < 19; k++)
         r[k] = (|(pend[k] & en[k])) & route[k];
      return r;
   endfunction : exp_irq

   // Reads every view of one group and of the route block, and the request lines
   task automatic check_grp(input int gi);
      logic e;
      apb(1'b0, gaddr(gi, gia_pkg::OFS_SRC), 32'h0, v, e);
      chk(v, {1'b0, pend[gi]});
      apb(1'b0, gaddr(gi, gia_pkg::OFS_ESET), 32'h0, v, e);
      chk(v, {1'b0, en[gi]});
      apb(1'b0, gaddr(gi, gia_pkg::OFS_ECLR), 32'h0, v, e);
      chk(v, {1'b0, en[gi]});
      apb(1'b0, gaddr(gi, gia_pkg::OFS_RES), 32'h0, v, e);
      chk(v, {1'b0, pend[gi] & en[gi]});
      apb(1'b0, gia_pkg::OFS_BSET, 32'h0, v, e);
      chk(v, {5'h00, route, 8'h00});
      apb(1'b0, gia_pkg::OFS_BCLR, 32'h0, v, e);
      chk(v, {5'h00, route, 8'h00});
      apb(1'b0, gia_pkg::OFS_BVEC, 32'h0, v, e);
      chk(v, {5'h00, exp_irq(), 8'h00});
      chk({13'h0000, irq}, {13'h0000, exp_irq()});
   endtask : check_grp

   task automatic fire_evt(input int gi, input logic [30:0] b);
      @(posedge i_sys_clk);
      fire  <= 1'b1;
      fgrp  <= 5'(gi);
      fbits <= b;
      @(posedge i_sys_clk);
      fire <= 1'b0;
      repeat (6) @(posedge i_sys_clk);
      pend[gi] = pend[gi] | (b & gia_pkg::IMPL_MASK[gi]);
   endtask : fire_evt

   // Main sequence
   initial begin
      logic e;
      seed = 32'h8a9c;
      {psel, penable, pwrite, fire} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      fgrp = 5'h00;
      fbits = 31'h00000000;
      route = 19'h00000;
      for (int k = 0; k < 19; k++) begin
         pend[k] = 31'h0;
         en[k] = 31'h0;
      end
      i_rst = 1'b1;
      repeat (16) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      @(posedge i_sys_clk);
      check_grp(0);
      check_grp(18);
      // Unmapped reserved word answers with an error and reads zero; a misaligned write is sent unchecked
      apb(1'b0, 12'h010, 32'h0, v, e);
      chk({v[31:1], e}, 32'h00000001);
      apb(1'b1, 12'h002, 32'hffffffff, v, e);
      // Corner: full group raised, then routing withdrawn through the clear word
      apb(1'b1, gaddr(0, gia_pkg::OFS_ESET), 32'hffffffff, v, e);
      en[0] = gia_pkg::IMPL_MASK[0];
      fire_evt(0, 31'h7fffffff);
      apb(1'b1, gia_pkg::OFS_BSET, 32'hffffffff, v, e);
      route = 19'h7ffff;
      check_grp(0);
      apb(1'b1, gia_pkg::OFS_BCLR, 32'hffffffff, v, e);
      route = 19'h00000;
      check_grp(0);
      // Random traffic over every register kind
      for (int it = 0; it < 120; it++) begin
         g = $unsigned($random(seed)) % 19;
         op = $unsigned($random(seed)) % 10;
         d = $random(seed);
         case (op)
            0, 1: fire_evt(g, d[30:0]);
            2: begin
               apb(1'b1, gaddr(g, gia_pkg::OFS_SRC), d, v, e);
               pend[g] = pend[g] & ~d[30:0];
            end
            3: begin
               apb(1'b1, gaddr(g, gia_pkg::OFS_ESET), d, v, e);
               en[g] = en[g] | (d[30:0] & gia_pkg::IMPL_MASK[g]);
            end
            4: begin
               apb(1'b1, gaddr(g, gia_pkg::OFS_ECLR), d, v, e);
               en[g] = en[g] & ~d[30:0];
            end
            5: apb(1'b1, gaddr(g, gia_pkg::OFS_RES), d, v, e);
            6: begin
               apb(1'b1, gia_pkg::OFS_BSET, d, v, e);
               route = route | d[26:8];
            end
            7: begin
               apb(1'b1, gia_pkg::OFS_BCLR, d, v, e);
               route = route & ~d[26:8];
            end
            8: apb(1'b1, gia_pkg::OFS_BVEC, d, v, e);
            default: apb(1'b1, gaddr(g, 12'h010), d, v, e);
         endcase
         check_grp(g);
      end
      tally_and_finish();
   end
endmodule : tb
